/* rtl/lpt_top.sv */
// Purpose: trigger fan-out, amplitude and enable registers, lamp flash
// Assumes: trigger inputs already synchronous to clk
// Notes:   analog driver shaping lives outside; dac codes are static levels
`timescale 1ns/1ps

// How it works
// RULE1 - accept backplane controller trigger input
// RULE2 - accept front panel external trigger input
// RULE3 - fire trigger is OR of both
// RULE4 - each channel dac gets 8-bit code
// RULE5 - twelve 8-bit readable writable amplitude registers
// RULE6 - 12-bit enable register selects responding channels
// RULE7 - flash indicator lamp when a channel fires
// RULE8 - each channel drives own monitor output
// RULE9 - cleared enable bit suppresses pulse and flash
module lpt_top #(
  parameter int unsigned LAMP_HOLD = lpt_pkg::LAMP_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ctrl_trig,
  input  wire logic                     ext_trig,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [lpt_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]              reg_wdata,
  output logic      [15:0]              reg_rdata,
  output logic [lpt_pkg::N_CHAN-1:0]    chan_fire,
  output logic [lpt_pkg::N_CHAN-1:0]    chan_monitor,
  output logic [lpt_pkg::N_CHAN*lpt_pkg::AMP_W-1:0] dac_code,
  output logic                          lamp
);

  // the stretch counter is 24 bits, longer holds cannot be served
  if (LAMP_HOLD < 1 || LAMP_HOLD > 32'h00ff_ffff) begin
    $error("LAMP_HOLD out of range");
  end

  logic [lpt_pkg::AMP_W-1:0]  amp_r [lpt_pkg::N_CHAN];
  logic [lpt_pkg::N_CHAN-1:0] enable_r;
  logic                       trig_prev_r;
  logic                       trig_any;
  logic                       trig_rise;
  logic [23:0]                lamp_cnt_r;

  // true when address hits an amplitude slot
  function automatic logic is_amp(input logic [3:0] a);
    return a < lpt_pkg::ENABLE_IDX;
  endfunction

  // RULE5 amplitude register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < lpt_pkg::N_CHAN; i++)
        amp_r[i] <= lpt_pkg::AMP_RESET;
    end else if (reg_wr && is_amp(reg_addr)) begin
      amp_r[reg_addr] <= reg_wdata[7:0];
    end
  end

  // RULE6 enable mask write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= lpt_pkg::ENABLE_RESET;
    end else if (reg_wr && reg_addr == lpt_pkg::ENABLE_IDX) begin
      enable_r <= reg_wdata[11:0];
    end
  end

  // registered read; unmapped indices read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (is_amp(reg_addr))
        reg_rdata <= {8'h00, amp_r[reg_addr]};
      else if (reg_addr == lpt_pkg::ENABLE_IDX)
        reg_rdata <= {4'h0, enable_r};
      else
        reg_rdata <= 16'h0000;
    end
  end

  // RULE4 dac codes follow amplitude registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_code <= '0;
    end else begin
      for (int i = 0; i < lpt_pkg::N_CHAN; i++)
        dac_code[i*lpt_pkg::AMP_W +: lpt_pkg::AMP_W] <= amp_r[i];
    end
  end

  // RULE1 RULE2 RULE3 trigger merge
  assign trig_any  = ctrl_trig | ext_trig;
  // edge detect so a long trigger fires once per arrival
  assign trig_rise = trig_any & ~trig_prev_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      trig_prev_r <= 1'b0;
    else
      trig_prev_r <= trig_any;
  end

  // RULE9 RULE8 gated per channel fire and monitor
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_fire    <= '0;
      chan_monitor <= '0;
    end else begin
      chan_fire    <= trig_rise ? enable_r : '0;
      chan_monitor <= trig_rise ? enable_r : '0;
    end
  end

  // RULE7 lamp stretch, restarted by each fire
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lamp_cnt_r <= 24'h000000;
      lamp       <= 1'b0;
    end else if (|chan_fire) begin
      lamp_cnt_r <= 24'(LAMP_HOLD - 1);
      lamp       <= 1'b1;
    end else if (lamp_cnt_r != 24'h000000) begin
      lamp_cnt_r <= lamp_cnt_r - 24'h000001;
    end else begin
      lamp       <= 1'b0;
    end
  end

  // RULE3 fire follows merged trigger edge
  property p_fire_on_trig;
    @(posedge clk) disable iff (!rst_n)
      trig_rise |=> chan_fire == $past(enable_r);
  endproperty
  a_fire_on_trig: assert property (p_fire_on_trig) // RULE3
    else $error("fire does not match enable on trigger");

  property p_no_fire_idle;
    @(posedge clk) disable iff (!rst_n)
      !trig_rise |=> chan_fire == '0;
  endproperty
  a_no_fire_idle: assert property (p_no_fire_idle) // RULE1
    else $error("channel fired without trigger");

  property p_ext_fires;
    @(posedge clk) disable iff (!rst_n)
      (ext_trig && !trig_prev_r && enable_r != '0) |=> |chan_fire;
  endproperty
  a_ext_fires: assert property (p_ext_fires) // RULE2
    else $error("external trigger did not fire");

  property p_dac_follow;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == 4'h3) |=> ##1
        dac_code[31:24] == $past(reg_wdata[7:0], 2);
  endproperty
  a_dac_follow: assert property (p_dac_follow) // RULE4
    else $error("dac code not updated from write");

  property p_amp_readback;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && is_amp(reg_addr)) |=>
        reg_rdata == {8'h00, $past(amp_r[reg_addr])};
  endproperty
  a_amp_readback: assert property (p_amp_readback) // RULE5
    else $error("amplitude readback mismatch");

  property p_en_readback;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == lpt_pkg::ENABLE_IDX) |=>
        reg_rdata == {4'h0, $past(enable_r)};
  endproperty
  a_en_readback: assert property (p_en_readback) // RULE6
    else $error("enable readback mismatch");

  property p_lamp_on;
    @(posedge clk) disable iff (!rst_n)
      |chan_fire |=> lamp;
  endproperty
  a_lamp_on: assert property (p_lamp_on) // RULE7
    else $error("lamp not lit after fire");

  property p_monitor_match;
    @(posedge clk) disable iff (!rst_n)
      chan_monitor == chan_fire;
  endproperty
  a_monitor_match: assert property (p_monitor_match) // RULE8
    else $error("monitor differs from fire");

  property p_masked_quiet;
    @(posedge clk) disable iff (!rst_n)
      (enable_r == '0 && !(reg_wr && reg_addr == lpt_pkg::ENABLE_IDX))
        |=> chan_fire == '0;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) // RULE9
    else $error("masked channel fired");

  // RULE5 written amplitude lands next cycle
  property p_amp_write;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && is_amp(reg_addr)) |=>
        amp_r[$past(reg_addr)] == $past(reg_wdata[7:0]);
  endproperty
  a_amp_write: assert property (p_amp_write) // RULE5
    else $error("amplitude write did not land");

  // RULE6 written mask lands next cycle
  property p_enable_write;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == lpt_pkg::ENABLE_IDX) |=>
        enable_r == $past(reg_wdata[11:0]);
  endproperty
  a_enable_write: assert property (p_enable_write) // RULE6
    else $error("enable mask write did not land");

  // RULE5 unmapped indices read zero
  property p_unmapped_read;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr > lpt_pkg::ENABLE_IDX) |=>
        reg_rdata == 16'h0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) // RULE5
    else $error("unmapped index read nonzero");

  // RULE3 held trigger fires only once
  property p_held_once;
    @(posedge clk) disable iff (!rst_n)
      (trig_any && trig_prev_r) |=> chan_fire == '0;
  endproperty
  a_held_once: assert property (p_held_once) // RULE3
    else $error("held trigger fired again");

  // RULE7 lamp holds while stretch runs
  property p_lamp_hold;
    @(posedge clk) disable iff (!rst_n)
      (lamp && lamp_cnt_r != 24'h000000) |=> lamp;
  endproperty
  a_lamp_hold: assert property (p_lamp_hold) // RULE7
    else $error("lamp dropped before hold ended");

  // RULE7 dark lamp stays dark without fire
  property p_lamp_dark;
    @(posedge clk) disable iff (!rst_n)
      (!lamp && chan_fire == '0) |=> !lamp;
  endproperty
  a_lamp_dark: assert property (p_lamp_dark) // RULE7
    else $error("lamp lit without a fire");

endmodule

/* rtl/lpt_pkg.sv */
// Purpose: constants for the led pulser trigger control block
// Assumes: 10 MHz clock, registers reached over a plain register port
// Notes:   register indices are word indices on the register port
package lpt_pkg;
  localparam int unsigned N_CHAN        = 12;
  localparam int unsigned AMP_W         = 8;
  localparam int unsigned ADDR_W        = 4;
  // register indices: amplitudes at 0..11, enable mask at 12
  localparam logic [3:0]  AMP_BASE_IDX  = 4'h0;
  localparam logic [3:0]  ENABLE_IDX    = 4'hc;
  localparam logic [7:0]  AMP_RESET     = 8'h00;
  localparam logic [11:0] ENABLE_RESET  = 12'h000;
  // indicator lamp stretch so a single fire is visible
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned LAMP_MS       = 50;
  localparam int unsigned LAMP_CYCLES   = CLK_HZ / 1000 * LAMP_MS;
  // width of each channel fire pulse in cycles
  localparam int unsigned FIRE_CYCLES   = 1;
endpackage

/* tb/lpt_trig_src.sv */
// Purpose: trigger source model, backplane and front panel
// Assumes: active high pulses, moved 10 ns after the edge
// Notes:   lines rest low between pulses
`timescale 1ns/1ps
module lpt_trig_src (
  input  wire logic clk,
  output logic      ctrl_trig,
  output logic      ext_trig
);
  initial {ext_trig, ctrl_trig} = 2'b00;
  task automatic fire(input logic [1:0] sel, input int len);
    @(posedge clk) #10;
    {ext_trig, ctrl_trig} = sel;
    repeat (len) @(posedge clk);
    #10 {ext_trig, ctrl_trig} = 2'b00;
  endtask
endmodule

/* tb/led_pulser_trigger_control_test.sv */
// Purpose: register and trigger checks for lpt_top
// Assumes: lamp hold shortened to 4 cycles
// Notes:   inputs move 10 ns after the rising edge
`timescale 1ns/1ps
module led_pulser_trigger_control_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [11:0] chan_fire;
  logic [11:0] chan_monitor;
  logic [95:0] dac_code;
  logic        lamp;
  logic        ctrl_trig;
  logic        ext_trig;
  logic [11:0] mask = 12'ha5c;
  int          fails = 0;
  int          checks = 0;
  int          fires = 0;
  always #50 clk = ~clk;
  lpt_top #(.LAMP_HOLD(4)) uut (.clk(clk), .rst_n(rst_n),
    .ctrl_trig(ctrl_trig), .ext_trig(ext_trig), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .chan_fire(chan_fire),
    .chan_monitor(chan_monitor), .dac_code(dac_code), .lamp(lamp));
  lpt_trig_src src (.clk(clk), .ctrl_trig(ctrl_trig), .ext_trig(ext_trig));
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) #10;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk) #10 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk) #10;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk) #10 reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // fire pulses counted away from the edge; monitor must mirror
  always @(negedge clk) if (chan_fire !== 12'h000) begin
    fires++;
    chk(chan_fire, mask);
    chk(chan_monitor, mask);
  end
  // watchdog, far beyond the expected run of under two hundred cycles
  initial begin
    #200000;
    fails++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge clk);
    #10 rst_n = 1'b1;
    for (int i = 0; i < 13; i++) rd(i[3:0], 16'h0000);
    // upper data bits set to show they are dropped
    for (int i = 0; i < 12; i++) wr(i[3:0], 16'hff10 + i[15:0]);
    wr(4'hc, {4'hf, mask});
    wr(4'hd, 16'h1234);
    rd(4'hd, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      rd(i[3:0], 16'h0010 + i[15:0]);
      chk(dac_code[8*i +: 8], 8'h10 + i[7:0]);
    end
    rd(4'hc, {4'h0, mask});
    for (int s = 1; s < 4; s++) begin
      src.fire(s[1:0], 1);
      #100 chk(lamp, 1'b1);
      #1000 chk(lamp, 1'b0);
    end
    chk(fires, 3);
    // a level held for five cycles fires only once
    src.fire(2'b01, 5);
    #1000 chk(fires, 4);
    wr(4'hc, 16'h0000);
    src.fire(2'b11, 1);
    #100 chk(lamp, 1'b0);
    #500 chk(fires, 4);
    // reset in mid run clears codes and registers again
    wr(4'h5, 16'h0077);
    wr(4'hc, 16'h0fff);
    @(posedge clk) #10 rst_n = 1'b0;
    #200 chk(dac_code, 96'h0);
    chk(lamp, 1'b0);
    rst_n = 1'b1;
    rd(4'h5, 16'h0000);
    rd(4'hc, 16'h0000);
    tally_and_finish;
  end
endmodule
